/* File: dv/pmf_framer_checker.sv */
// Purpose: Port-level assertions on the packet-mode framer.
// Assumes: One core clock domain with a synchronous active-low reset.
// Notes: Attached by bind; the SPI pins are async, so margins allow sync.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_consts.vh"
module pmf_framer_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic spiSclk,
  input wire logic spiSsN,
  input wire logic spiMosi,
  input wire logic spiMisoOut,
  input wire logic spiMisoOe,
  input wire logic irq,
  input wire logic [3:0] channelSel,
  input wire logic rxOn,
  input wire logic txOn,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  input wire logic [7:0] energyLevel
);
  logic [7:0] txCnt;
  logic [3:0] sinceSel;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Accepted radio bytes in the current frame, cleared between frames
  always @(posedge clk) begin
    if (!rst_n || !txOn) txCnt <= 8'h00;
    else if (txValid && txReady) txCnt <= txCnt + 8'h01;
  end
  // Age of the last selected cycle; flags may only clear near a host access
  always @(posedge clk) begin
    if (!rst_n) sinceSel <= 4'hF;
    else if (!spiSsN) sinceSel <= 4'h0;
    else if (sinceSel != 4'hF) sinceSel <= sinceSel + 4'h1;
  end

  a_oe_select: assert property (
    $fell(spiSsN) |-> ##[1:5] spiMisoOe)
    else $error("MISO enable late after select");
  a_miso_idle: assert property (
    spiSsN [*5] |-> !spiMisoOe && !spiMisoOut)
    else $error("MISO active while deselected");
  a_byte_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txByte))
    else $error("Radio byte dropped or changed before acceptance");
  a_valid_in_tx: assert property (txValid |-> txOn)
    else $error("Radio byte offered outside a transmit frame");
  a_tx_start: assert property (
    $rose(txOn) |-> txValid && txByte == `PMF_PREAMBLE_BYTE)
    else $error("Frame did not open with a preamble byte");
  a_preamble_bytes: assert property (
    txValid && txReady && txCnt < 8'h04 |-> txByte == `PMF_PREAMBLE_BYTE)
    else $error("Preamble byte wrong");
  a_delim_byte: assert property (
    txValid && txReady && txCnt == 8'h04 |-> txByte == `PMF_DELIM_BYTE)
    else $error("Delimiter byte wrong");
  a_len_range: assert property (
    txValid && txReady && txCnt == 8'h05 |->
      txByte >= 8'h02 && txByte <= `PMF_MAX_FRAME)
    else $error("Length byte out of range");
  a_irq_after_tx: assert property ($fell(txOn) |-> ##[1:2] irq)
    else $error("No interrupt after transmit end");
  a_irq_clear: assert property ($fell(irq) |-> sinceSel < 4'h8)
    else $error("Interrupt cleared without host access");

  c_tx_stall: cover property (txValid && !txReady);
  c_irq: cover property ($rose(irq));
  c_rx_armed: cover property (rxValid && rxOn);
  c_tx_end: cover property ($fell(txOn));
endmodule // pmf_framer_checker

bind pmf_framer pmf_framer_checker chk_u (
  .clk, .rst_n, .ce, .spiSclk, .spiSsN, .spiMosi, .spiMisoOut, .spiMisoOe,
  .irq, .channelSel, .rxOn, .txOn, .txByte, .txValid, .txReady, .rxByte,
  .rxValid, .energyLevel
);
`default_nettype wire

/* File: dv/pmf_framer_tb.sv */
// Purpose: Self-checking bench of the packet-mode framer.
// Assumes: Host model on the SPI pins; radio ends driven here.
// Notes: Link-quality and channel-check windows run at full length.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_consts.vh"
module pmf_framer_tb;
  logic clk, rst_n, txReady, rxValid;
  logic [7:0] rxByte, energyLevel;
  logic [1:0] stallCnt;
  wire spiSclk, spiSsN, spiMosi, spiMisoOut, spiMisoOe, irq, rxOn, txOn;
  wire txValid;
  wire [3:0] channelSel;
  wire [7:0] txByte;
  logic [7:0] txq [$];
  int n_mismatch, n_compared;

  pmf_framer dut_u (.clk, .rst_n, .ce(1'b1), .spiSclk, .spiSsN, .spiMosi,
    .spiMisoOut, .spiMisoOe, .irq, .channelSel, .rxOn, .txOn, .txByte,
    .txValid, .txReady, .rxByte, .rxValid, .energyLevel);
  pmf_host_model host_u (.spiSclk, .spiSsN, .spiMosi, .spiMisoOut,
    .spiMisoOe);

  // Core clock, 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Radio sink stalls every fourth cycle so held bytes get exercised
  always @(negedge clk) begin
    stallCnt <= stallCnt + 2'h1;
    txReady <= (stallCnt != 2'h3);
  end
  // Bytes are captured at the edge where the handshake completes
  always @(posedge clk) begin
    if (txValid === 1'b1 && txReady === 1'b1) txq.push_back(txByte);
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] pb(input int k);
    return 8'h31 + k[7:0] * 8'h07;
  endfunction
  // Reflected CRC, one byte LSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++)
      x = (x[0] ^ d[i]) ? (x >> 1) ^ `PMF_CRC_POLY_REV : x >> 1;
    return x;
  endfunction
  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    host_u.wrBuf[0] = w;
    host_u.frame({1'b0, a}, 1);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] w);
    host_u.frame({1'b1, a}, 1);
    w = host_u.rdBuf[0];
  endtask
  // Bounded wait; the caller judges the level
  task automatic wait_irq(input int maxCyc);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < maxCyc) begin
      @(negedge clk);
      i++;
    end
  endtask
  // One strobe per byte; the idle byte is scrambled, not left stale
  task automatic rx_send(input logic [7:0] b);
    @(negedge clk);
    rxByte = b;
    rxValid = 1'b1;
    @(negedge clk);
    rxValid = 1'b0;
    rxByte = ~b;
  endtask
  task automatic rx_frame(input logic [7:0] len, input int nPay,
                          input bit bad);
    logic [15:0] c;
    c = `PMF_CRC_INIT;
    for (int i = 0; i < 4; i++) rx_send(`PMF_PREAMBLE_BYTE);
    rx_send(`PMF_DELIM_BYTE);
    rx_send(len);
    for (int k = 0; k < nPay; k++) begin
      rx_send(pb(k));
      c = crc_byte(c, pb(k));
    end
    rx_send(c[7:0] ^ {7'h00, bad});
    rx_send(c[15:8]);
  endtask

  task automatic test_chan;
    logic [15:0] r;
    for (int ch = 0; ch < 16; ch++) begin
      wr(`PMF_ADDR_CTRL, {8'h00, ch[3:0], 4'h0});
      check("channelSel", {12'h000, channelSel}, {12'h000, ch[3:0]});
    end
    rd(`PMF_ADDR_CTRL, r);
    check("ctrlChan", {12'h000, r[7:4]}, 16'h000F);
  endtask
  task automatic test_tx(input int n);
    logic [15:0] c, s;
    int w;
    w = (n + 1) / 2;
    txq.delete();
    wr(`PMF_ADDR_TXLEN, n[15:0]);
    for (int k = 0; k < w; k++) host_u.wrBuf[k] = {pb(2 * k + 1), pb(2 * k)};
    host_u.frame({1'b0, `PMF_ADDR_TXDATA}, w);
    wr(`PMF_ADDR_CTRL, 16'h0001);
    wait_irq(3000);
    check("irqTx", {15'h0000, irq}, 16'h0001);
    check("txCount", 16'(txq.size()), 16'(n + 8));
    for (int i = 0; i < 4; i++)
      check("preamble", {8'h00, txq[i]}, 16'h0000);
    check("delim", {8'h00, txq[4]}, {8'h00, `PMF_DELIM_BYTE});
    check("lenByte", {8'h00, txq[5]}, 16'(n + 2));
    c = `PMF_CRC_INIT;
    for (int k = 0; k < n; k++) begin
      check("payload", {8'h00, txq[6 + k]}, {8'h00, pb(k)});
      c = crc_byte(c, pb(k));
    end
    check("fcs", {txq[n + 7], txq[n + 6]}, c);
    rd(`PMF_ADDR_STATUS, s);
    check("txFlag", s & 16'h0002, 16'h0002);
    check("irqClear", {15'h0000, irq}, 16'h0000);
  endtask
  task automatic test_rx;
    logic [15:0] s, c;
    @(negedge clk);
    energyLevel = 8'h40;
    wr(`PMF_ADDR_CTRL, 16'h0002);
    rx_frame(8'h80, 0, 1'b0);  // Over-long length must be dropped
    rx_frame(8'h06, 4, 1'b0);
    check("irqEarly", {15'h0000, irq}, 16'h0000);
    wait_irq(14000);
    check("irqRx", {15'h0000, irq}, 16'h0001);
    rd(`PMF_ADDR_STATUS, s);
    check("crcOk", s & 16'h0014, 16'h0014);
    rd(`PMF_ADDR_RXLEN, s);
    check("rxLen", s, 16'h0004);
    host_u.frame({1'b1, `PMF_ADDR_RXDATA}, 2);
    check("rxWord0", host_u.rdBuf[0], {pb(1), pb(0)});
    check("rxWord1", host_u.rdBuf[1], {pb(3), pb(2)});
    rd(`PMF_ADDR_RXDATA, s); // A new frame resumes at word 2
    c = `PMF_CRC_INIT;
    for (int k = 0; k < 4; k++) c = crc_byte(c, pb(k));
    check("rxWord2", s, c);
    rd(`PMF_ADDR_ENERGY, s);
    check("linkQual", {8'h00, s[15:8]}, 16'h0040);
    wr(`PMF_ADDR_CTRL, 16'h0002);
    rx_frame(8'h06, 4, 1'b1);
    wait_irq(14000);
    rd(`PMF_ADDR_STATUS, s);
    check("crcBad", s & 16'h0014, 16'h0004);
  endtask
  task automatic test_chk;
    logic [15:0] s;
    @(negedge clk);
    energyLevel = 8'h5A;
    wr(`PMF_ADDR_CTRL, 16'h0004);
    wait_irq(27000);
    rd(`PMF_ADDR_STATUS, s);
    check("chkFlag", s & 16'h0008, 16'h0008);
    rd(`PMF_ADDR_ENERGY, s);
    check("chkLevel", {8'h00, s[7:0]}, 16'h005A);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    rxValid = 1'b0;
    rxByte = 8'h00;
    energyLevel = 8'h00;
    txReady = 1'b0;
    stallCnt = 2'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (5) @(negedge clk);
    check("resetOuts", {7'h00, irq, txOn, rxOn, txValid, spiMisoOe,
                        channelSel}, 16'h0000);
    rst_n = 1'b1;
    @(negedge clk);
    test_chan;
    test_tx(1);
    test_tx(125);
    test_rx;
    test_chk;
    end_of_test;
  end
  // Watchdog, about a tenth past the expected run length
  initial begin
    repeat (110000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule // pmf_framer_tb
`default_nettype wire

/* File: dv/pmf_host_model.sv */
// Purpose: Host side of the four-wire SPI link, mode 0, 8 MHz.
// Assumes: Link clock of 125 ns, parked low outside frames.
// Notes: An undriven MISO reads as the inverse of its last driven bit.
`timescale 1ns/1ps
`default_nettype none
module pmf_host_model (
  output logic spiSclk,
  output logic spiSsN,
  output logic spiMosi,
  input wire logic spiMisoOut,
  input wire logic spiMisoOe
);
  logic [15:0] wrBuf [0:63];
  logic [15:0] rdBuf [0:63];
  logic lastBit;
  wire misoWire = spiMisoOe ? spiMisoOut : ~lastBit;

  // Idle link: deselected, clock still
  initial begin
    spiSclk = 1'b0;
    spiSsN = 1'b1;
    spiMosi = 1'b0;
    lastBit = 1'b0;
  end
  // Remember the driven level so a released line never looks held
  always @* begin
    if (spiMisoOe) lastBit = spiMisoOut;
  end
  // One bit: data set in the low phase, both ends sample on the rise
  task automatic bit_x(input logic b, output logic r);
    spiMosi = b;
    #62.5;
    spiSclk = 1'b1;
    r = misoWire;
    #62.5;
    spiSclk = 1'b0;
  endtask
  // Command byte then whole 16-bit words, MSB first
  task automatic frame(input logic [7:0] cmd, input int nWords);
    logic r;
    logic [15:0] w;
    spiSsN = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) bit_x(cmd[i], r);
    for (int k = 0; k < nWords; k++) begin
      for (int i = 15; i >= 0; i--) begin
        bit_x(wrBuf[k][i], r);
        w[i] = r;
      end
      rdBuf[k] = w;
    end
    #100;
    spiSsN = 1'b1;
    spiMosi = ~spiMosi;
    #200;
  endtask
endmodule // pmf_host_model
`default_nettype wire

/* File: src/pmf_consts.vh */
// Purpose: Shared constants of the packet-mode framer and buffer.
// Assumes: Core clock of 200 MHz; one energy sample per microsecond.
// Notes:   Definitions only; included by bare name.
`ifndef PMF_CONSTS_VH
`define PMF_CONSTS_VH

// Clock and timing
`define PMF_CLK_MHZ 200
`define PMF_US_CYC (`PMF_CLK_MHZ * 1)
`define PMF_LQ_WINDOW_US 64
`define PMF_LQ_SAMPLES (`PMF_LQ_WINDOW_US * 1)
`define PMF_CHK_WINDOW_US 128
`define PMF_CHK_SAMPLES (`PMF_CHK_WINDOW_US * 1)

// Buffers and frame layout
`define PMF_BUF_DEPTH 64
`define PMF_BUF_WIDTH 16
`define PMF_PREAMBLE_LEN 3'h4
`define PMF_PREAMBLE_BYTE 8'h00
`define PMF_DELIM_BYTE 8'hA7
`define PMF_MAX_PAYLOAD 7'h7D
`define PMF_FCS_LEN 7'h02
`define PMF_MAX_FRAME 8'h7F
`define PMF_LQ_WORD 6'h3F
`define PMF_CRC_INIT 16'h0000
`define PMF_CRC_POLY_REV 16'h8408

// Host command addresses (command byte bits 6:0, bit 7 = read)
`define PMF_ADDR_CTRL 7'h00
`define PMF_ADDR_STATUS 7'h01
`define PMF_ADDR_TXLEN 7'h02
`define PMF_ADDR_RXLEN 7'h03
`define PMF_ADDR_TXDATA 7'h04
`define PMF_ADDR_RXDATA 7'h05
`define PMF_ADDR_ENERGY 7'h06

// Control word fields
`define PMF_CTRL_TXGO 0
`define PMF_CTRL_RXON 1
`define PMF_CTRL_CHKGO 2
`define PMF_CTRL_CH_LO 4
`define PMF_CTRL_CH_HI 7
`define PMF_CHAN_RESET 4'h0

`endif

/* File: src/pmf_energy_avg.v */
// Purpose: Averages an energy level over a fixed window of samples.
// Assumes: SAMPLES is a power of two; level comes from the same clock.
// Notes:   A start while busy restarts the window.
`timescale 1ns/1ps
`default_nettype none
module pmf_energy_avg #(
  parameter integer SAMPLES = 64,
  parameter integer TICK_CYC = 200
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire start,
  input wire [7:0] level,
  output reg busy,
  output reg done,
  output reg [7:0] result
);
  localparam integer SHIFT = $clog2(SAMPLES);
  localparam integer TW = $clog2(TICK_CYC);
  localparam integer TICK_END = TICK_CYC - 1;
  localparam integer CNT_END = SAMPLES - 1;
  localparam [TW-1:0] TICK_LAST = TICK_END[TW-1:0];
  localparam [SHIFT-1:0] CNT_LAST = CNT_END[SHIFT-1:0];

  reg [TW-1:0] tick_reg;
  reg [SHIFT-1:0] cnt_reg;
  reg [SHIFT+7:0] sum_reg;
  wire [SHIFT+7:0] sum_next = sum_reg + {{SHIFT{1'b0}}, level};

  // One sample per tick; the mean is the sum shifted down
  always @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      result <= 8'h00;
      tick_reg <= {TW{1'b0}};
      cnt_reg <= {SHIFT{1'b0}};
      sum_reg <= {(SHIFT+8){1'b0}};
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        tick_reg <= {TW{1'b0}};
        cnt_reg <= {SHIFT{1'b0}};
        sum_reg <= {(SHIFT+8){1'b0}};
      end else if (busy) begin
        if (tick_reg == TICK_LAST) begin
          tick_reg <= {TW{1'b0}};
          sum_reg <= sum_next;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_LAST) begin
            busy <= 1'b0;
            done <= 1'b1;
            result <= sum_next[SHIFT+7:SHIFT];
          end
        end else begin
          tick_reg <= tick_reg + 1'b1;
        end
      end
    end
  end
endmodule // pmf_energy_avg
`default_nettype wire

/* File: src/pmf_framer.v */
// Purpose: Packet-mode framer with transmit and receive packet buffers.
// Assumes: Host on a mode 0 SPI port; radio byte streams on this clock.
// Notes:   SPI pins are synchronised; SPI clock must stay at or below 8 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_consts.vh"

// Behaviour
// - Transmit and receive buffers are each 64 words of 16 bits.
// - Payloads of any length up to 125 bytes go both ways.
// - Transmit sends four preamble bytes, a delimiter, then a length byte.
// - Transmit appends a check sequence computed over the payload.
// - Receive checks the two check bytes and reports pass or fail.
// - Receive finds preamble, delimiter and length, then buffers the rest.
// - Link quality is averaged for 64 us after the preamble and buffered.
// - The interrupt for receive rises only once the whole packet is stored.
// - The interrupt rises when the whole packet has been sent.
// - A channel check averages energy and reports the level to the host.
// - All host traffic uses the four-wire SPI port and one interrupt.
// - The host picks one of sixteen channels for both directions.
module pmf_framer (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire spiSclk,
  input wire spiSsN,
  input wire spiMosi,
  output reg spiMisoOut,
  output reg spiMisoOe,
  output reg irq,
  output reg [3:0] channelSel,
  output reg rxOn,
  output reg txOn,
  output reg [7:0] txByte,
  output reg txValid,
  input wire txReady,
  input wire [7:0] rxByte,
  input wire rxValid,
  input wire [7:0] energyLevel
);
  localparam [2:0] TX_IDLE = 3'd0, TX_PRE = 3'd1, TX_DELIM = 3'd2,
    TX_LEN = 3'd3, TX_DATA = 3'd4, TX_FCS1 = 3'd5, TX_FCS2 = 3'd6;
  localparam [2:0] RX_IDLE = 3'd0, RX_PRE = 3'd1, RX_DELIM = 3'd2,
    RX_LEN = 3'd3, RX_DATA = 3'd4, RX_FIN = 3'd5;

  // Bit-serial update of the reflected CRC, LSB first
  function [15:0] crcByte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ `PMF_CRC_POLY_REV;
        else
          r = r >> 1;
      end
      crcByte = r;
    end
  endfunction

  reg [15:0] txMem [0:`PMF_BUF_DEPTH-1];
  reg [15:0] rxMem [0:`PMF_BUF_DEPTH-1];

  // Pin synchronisers; stage 0 feeds only stage 1
  reg [2:0] sclkSync_reg;
  reg [1:0] ssSync_reg;
  reg [1:0] mosiSync_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      sclkSync_reg <= 3'h0;
      ssSync_reg <= 2'h3;
      mosiSync_reg <= 2'h0;
    end else if (ce) begin
      sclkSync_reg <= {sclkSync_reg[1:0], spiSclk};
      ssSync_reg <= {ssSync_reg[0], spiSsN};
      mosiSync_reg <= {mosiSync_reg[0], spiMosi};
    end
  end
  wire sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2];
  wire sclkFall = ~sclkSync_reg[1] & sclkSync_reg[2];
  wire ssActive = ~ssSync_reg[1];

  // Host-side state
  reg [14:0] shiftIn_reg;
  reg [15:0] shiftOut_reg;
  reg [3:0] bitCnt_reg;
  reg inData_reg;
  reg cmdRead_reg;
  reg [6:0] cmdAddr_reg;
  reg [6:0] txLen_reg;
  reg [5:0] txWrPtr_reg;
  reg [5:0] rxRdPtr_reg;
  reg txGo_reg;
  reg chkGo_reg;
  reg txFlag_reg, rxFlag_reg, chkFlag_reg;
  // Radio-side state
  reg [2:0] txState_reg;
  reg [6:0] txIdx_reg;
  reg [15:0] txCrc_reg;
  reg txDone_reg;
  reg [2:0] rxState_reg;
  reg [2:0] preCnt_reg;
  reg [6:0] rxIdx_reg;
  reg [6:0] frameLen_reg;
  reg [6:0] rxLen_reg;
  reg [15:0] rxCrc_reg;
  reg crcOk_reg;
  reg rxDone_reg;
  reg lqStart_reg;
  wire chkBusy, chkDone, lqBusy;
  wire [7:0] chkLevel, linkQuality;

  wire [15:0] inWord = {shiftIn_reg, mosiSync_reg[1]};
  wire cmdDone = sclkRise & ~inData_reg & (bitCnt_reg == 4'h7);
  wire wordDone = sclkRise & inData_reg & (bitCnt_reg == 4'hF);
  wire [6:0] rdAddr = inData_reg ? cmdAddr_reg : inWord[6:0];
  wire hostRd = (cmdDone & inWord[7]) | (wordDone & cmdRead_reg);
  wire hostWr = wordDone & ~cmdRead_reg;
  wire txBusy = (txState_reg != TX_IDLE);
  wire stRead = cmdDone & inWord[7] & (inWord[6:0] == `PMF_ADDR_STATUS);

  // Word the host reads next; sampled as the shift-out load
  reg [15:0] rdWord;
  always @* begin
    case (rdAddr)
      `PMF_ADDR_CTRL: rdWord = {8'h00, channelSel, 1'b0, chkBusy, rxOn,
        txBusy};
      `PMF_ADDR_STATUS: rdWord = {9'h000, chkBusy, txBusy, crcOk_reg,
        chkFlag_reg, rxFlag_reg, txFlag_reg, rxOn};
      `PMF_ADDR_TXLEN: rdWord = {9'h000, txLen_reg};
      `PMF_ADDR_RXLEN: rdWord = {9'h000, rxLen_reg};
      `PMF_ADDR_RXDATA: rdWord = rxMem[rxRdPtr_reg + {5'h00, wordDone}];
      `PMF_ADDR_ENERGY: rdWord = {linkQuality, chkLevel};
      default: rdWord = 16'h0000;
    endcase
  end

  // SPI slave: 8-bit command, then 16-bit words MSB first
  always @(posedge clk) begin
    if (!rst_n) begin
      shiftIn_reg <= 15'h0000;
      shiftOut_reg <= 16'h0000;
      bitCnt_reg <= 4'h0;
      inData_reg <= 1'b0;
      cmdRead_reg <= 1'b0;
      cmdAddr_reg <= 7'h00;
      spiMisoOut <= 1'b0;
      spiMisoOe <= 1'b0;
    end else if (ce) begin
      spiMisoOe <= ssActive;
      if (!ssActive) begin
        bitCnt_reg <= 4'h0;
        inData_reg <= 1'b0;
        spiMisoOut <= 1'b0;
      end else begin
        if (sclkRise) begin
          shiftIn_reg <= inWord[14:0];
          bitCnt_reg <= (cmdDone | wordDone) ? 4'h0 : bitCnt_reg + 4'h1;
        end
        if (cmdDone) begin
          inData_reg <= 1'b1;
          cmdRead_reg <= inWord[7];
          cmdAddr_reg <= inWord[6:0];
        end
        if (hostRd)
          shiftOut_reg <= rdWord;
        else if (sclkFall && inData_reg)
          shiftOut_reg <= {shiftOut_reg[14:0], 1'b0};
        if (sclkFall)
          spiMisoOut <= inData_reg & shiftOut_reg[15];
      end
    end
  end

  // Host writes: transmit buffer fill, ignored while sending
  always @(posedge clk) begin
    if (ce && hostWr && rdAddr == `PMF_ADDR_TXDATA && !txBusy)
      txMem[txWrPtr_reg] <= inWord;
  end

  // Host control, event flags and interrupt
  always @(posedge clk) begin
    if (!rst_n) begin
      channelSel <= `PMF_CHAN_RESET;
      rxOn <= 1'b0;
      txLen_reg <= 7'h00;
      txWrPtr_reg <= 6'h00;
      rxRdPtr_reg <= 6'h00;
      txGo_reg <= 1'b0;
      chkGo_reg <= 1'b0;
      txFlag_reg <= 1'b0;
      rxFlag_reg <= 1'b0;
      chkFlag_reg <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      txGo_reg <= 1'b0;
      chkGo_reg <= 1'b0;
      if (rxDone_reg)
        rxOn <= 1'b0; // Hold the stored packet until the host re-arms
      if (hostWr) begin
        case (rdAddr)
          `PMF_ADDR_CTRL: begin
            channelSel <= inWord[`PMF_CTRL_CH_HI:`PMF_CTRL_CH_LO];
            rxOn <= inWord[`PMF_CTRL_RXON];
            txGo_reg <= inWord[`PMF_CTRL_TXGO];
            chkGo_reg <= inWord[`PMF_CTRL_CHKGO];
          end
          `PMF_ADDR_TXLEN: begin
            if (!txBusy) begin
              txLen_reg <= inWord[6:0];
              txWrPtr_reg <= 6'h00;
            end
          end
          `PMF_ADDR_TXDATA: begin
            if (!txBusy)
              txWrPtr_reg <= txWrPtr_reg + 6'h01;
          end
          default: begin
          end
        endcase
      end
      if (hostRd && rdAddr == `PMF_ADDR_RXLEN)
        rxRdPtr_reg <= 6'h00;
      else if (wordDone && cmdRead_reg && rdAddr == `PMF_ADDR_RXDATA)
        rxRdPtr_reg <= rxRdPtr_reg + 6'h01;
      // A new event wins over a status read in the same cycle
      txFlag_reg <= (txFlag_reg & ~stRead) | txDone_reg;
      rxFlag_reg <= (rxFlag_reg & ~stRead) | rxDone_reg;
      chkFlag_reg <= (chkFlag_reg & ~stRead) | chkDone;
      irq <= ((txFlag_reg | rxFlag_reg | chkFlag_reg) & ~stRead) |
        txDone_reg | rxDone_reg | chkDone;
    end
  end

  // Transmit framer
  wire txAccept = txValid & txReady;
  wire [6:0] txRdIdx = (txState_reg == TX_LEN) ? 7'h00 : txIdx_reg + 7'h01;
  wire [15:0] txRdWord = txMem[txRdIdx[6:1]];
  wire [7:0] txRdByte = txRdIdx[0] ? txRdWord[15:8] : txRdWord[7:0];
  wire [15:0] txCrcNext = crcByte(txCrc_reg, txByte);
  always @(posedge clk) begin
    if (!rst_n) begin
      txState_reg <= TX_IDLE;
      txIdx_reg <= 7'h00;
      txCrc_reg <= `PMF_CRC_INIT;
      txByte <= 8'h00;
      txValid <= 1'b0;
      txOn <= 1'b0;
      txDone_reg <= 1'b0;
    end else if (ce) begin
      txDone_reg <= 1'b0;
      case (txState_reg)
        TX_IDLE: begin
          // Lengths above the payload limit are never sent
          if (txGo_reg && txLen_reg <= `PMF_MAX_PAYLOAD) begin
            txState_reg <= TX_PRE;
            txIdx_reg <= 7'h00;
            txCrc_reg <= `PMF_CRC_INIT;
            txByte <= `PMF_PREAMBLE_BYTE;
            txValid <= 1'b1;
            txOn <= 1'b1;
          end
        end
        TX_PRE: if (txAccept) begin
          if (txIdx_reg[2:0] == `PMF_PREAMBLE_LEN - 3'h1) begin
            txByte <= `PMF_DELIM_BYTE;
            txState_reg <= TX_DELIM;
          end else begin
            txIdx_reg <= txIdx_reg + 7'h01;
          end
        end
        TX_DELIM: if (txAccept) begin
          txByte <= {1'b0, txLen_reg + `PMF_FCS_LEN};
          txState_reg <= TX_LEN;
        end
        TX_LEN: if (txAccept) begin
          txIdx_reg <= 7'h00;
          if (txLen_reg == 7'h00) begin
            txByte <= txCrc_reg[7:0];
            txState_reg <= TX_FCS1;
          end else begin
            txByte <= txRdByte;
            txState_reg <= TX_DATA;
          end
        end
        TX_DATA: if (txAccept) begin
          txCrc_reg <= txCrcNext;
          if (txIdx_reg == txLen_reg - 7'h01) begin
            txByte <= txCrcNext[7:0];
            txState_reg <= TX_FCS1;
          end else begin
            txIdx_reg <= txIdx_reg + 7'h01;
            txByte <= txRdByte;
          end
        end
        TX_FCS1: if (txAccept) begin
          txByte <= txCrc_reg[15:8];
          txState_reg <= TX_FCS2;
        end
        TX_FCS2: if (txAccept) begin
          txValid <= 1'b0;
          txOn <= 1'b0;
          txDone_reg <= 1'b1;
          txState_reg <= TX_IDLE;
        end
        default: txState_reg <= TX_IDLE;
      endcase
    end
  end

  // Receive deframer; bytes land low lane first
  wire [5:0] rxWordIdx = rxIdx_reg[6:1];
  always @(posedge clk) begin
    if (ce && rxState_reg == RX_DATA && rxValid) begin
      if (rxIdx_reg[0])
        rxMem[rxWordIdx] <= {rxByte, rxMem[rxWordIdx][7:0]};
      else
        rxMem[rxWordIdx] <= {rxMem[rxWordIdx][15:8], rxByte};
    end else if (ce && rxState_reg == RX_FIN && !lqBusy) begin
      rxMem[`PMF_LQ_WORD] <= {linkQuality, rxMem[`PMF_LQ_WORD][7:0]};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rxState_reg <= RX_IDLE;
      preCnt_reg <= 3'h0;
      rxIdx_reg <= 7'h00;
      frameLen_reg <= 7'h00;
      rxLen_reg <= 7'h00;
      rxCrc_reg <= `PMF_CRC_INIT;
      crcOk_reg <= 1'b0;
      rxDone_reg <= 1'b0;
      lqStart_reg <= 1'b0;
    end else if (ce) begin
      rxDone_reg <= 1'b0;
      lqStart_reg <= 1'b0;
      if (!rxOn && rxState_reg != RX_FIN) begin
        rxState_reg <= RX_IDLE; // Host turned receive off mid-frame
      end else begin
        case (rxState_reg)
          RX_IDLE: begin
            if (rxOn && !rxDone_reg) begin
              rxState_reg <= RX_PRE;
              preCnt_reg <= 3'h0;
            end
          end
          RX_PRE: if (rxValid) begin
            if (rxByte != `PMF_PREAMBLE_BYTE) begin
              preCnt_reg <= 3'h0;
            end else if (preCnt_reg == `PMF_PREAMBLE_LEN - 3'h1) begin
              rxState_reg <= RX_DELIM;
              lqStart_reg <= 1'b1;
            end else begin
              preCnt_reg <= preCnt_reg + 3'h1;
            end
          end
          RX_DELIM: if (rxValid) begin
            if (rxByte == `PMF_DELIM_BYTE) begin
              rxState_reg <= RX_LEN;
            end else if (rxByte != `PMF_PREAMBLE_BYTE) begin
              rxState_reg <= RX_PRE;
              preCnt_reg <= 3'h0;
            end
          end
          RX_LEN: if (rxValid) begin
            // Too long, or too short to hold the check bytes
            if (rxByte > `PMF_MAX_FRAME ||
                rxByte < {1'b0, `PMF_FCS_LEN}) begin
              rxState_reg <= RX_PRE;
              preCnt_reg <= 3'h0;
            end else begin
              frameLen_reg <= rxByte[6:0];
              rxIdx_reg <= 7'h00;
              rxCrc_reg <= `PMF_CRC_INIT;
              rxState_reg <= RX_DATA;
            end
          end
          RX_DATA: if (rxValid) begin
            rxCrc_reg <= crcByte(rxCrc_reg, rxByte);
            if (rxIdx_reg == frameLen_reg - 7'h01)
              rxState_reg <= RX_FIN;
            else
              rxIdx_reg <= rxIdx_reg + 7'h01;
          end
          RX_FIN: begin
            // Wait for the quality window, then announce the packet
            if (!lqBusy) begin
              rxLen_reg <= frameLen_reg - `PMF_FCS_LEN;
              crcOk_reg <= (rxCrc_reg == `PMF_CRC_INIT);
              rxDone_reg <= 1'b1;
              rxState_reg <= RX_IDLE;
            end
          end
          default: rxState_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // Energy averagers for the channel check and for link quality
  pmf_energy_avg #(
    .SAMPLES(`PMF_CHK_SAMPLES),
    .TICK_CYC(`PMF_US_CYC)
  ) chkAvg (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(chkGo_reg),
    .level(energyLevel),
    .busy(chkBusy),
    .done(chkDone),
    .result(chkLevel)
  );

  pmf_energy_avg #(
    .SAMPLES(`PMF_LQ_SAMPLES),
    .TICK_CYC(`PMF_US_CYC)
  ) lqAvg (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(lqStart_reg),
    .level(energyLevel),
    .busy(lqBusy),
    .done(),
    .result(linkQuality)
  );
endmodule // pmf_framer
`default_nettype wire
